// ===== logic/sag_defs.vh
`ifndef SAG_DEFS_VH
`define SAG_DEFS_VH

`define SAG_MODE_REAL   3'h0
`define SAG_MODE_V86    3'h1
`define SAG_MODE_PROT   3'h2
`define SAG_MODE_COMPAT 3'h3
`define SAG_MODE_LONG64 3'h4

`define SAG_SEG_EXTRA   3'h0
`define SAG_SEG_CODE    3'h1
`define SAG_SEG_STACK   3'h2
`define SAG_SEG_DATA    3'h3
`define SAG_SEG_AUX1    3'h4
`define SAG_SEG_AUX2    3'h5

`define SAG_TBL_GLOBAL  2'h0
`define SAG_TBL_LOCAL   2'h1
`define SAG_TBL_INTR    2'h2
`define SAG_TBL_TASK    2'h3

`define SAG_ATTR_DPL_LO 5
`define SAG_ATTR_DPL_HI 6
`define SAG_ATTR_LONG   13
`define SAG_ATTR_DSIZE  14

`define SAG_SEL_TI      2
`define SAG_REAL_SHIFT  4
`define SAG_DESC_SHIFT  3
`define SAG_RIVT_SHIFT  2
`define SAG_LIVT_SHIFT  4

`define SAG_RST_LIMIT   32'h0000ffff
`define SAG_RST_ATTR    16'h0093
`define SAG_RST_SEL     16'h0000
`define SAG_RST_BASE    64'h0000000000000000
`define SAG_REAL_MASK   64'h00000000000fffff
`define SAG_LOW4G_MASK  64'h00000000ffffffff

`endif

// ===== logic/sag_seg_addr_gen.v
`include "sag_defs.vh"

module sag_seg_addr_gen (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        mode_wr,
    input  wire [2:0]  mode_val,
    output wire [2:0]  mode_cur,
    input  wire        seg_ld,
    input  wire        far_ld,
    input  wire [2:0]  seg_idx,
    input  wire [15:0] seg_sel,
    output wire        ld_busy,
    output reg         ld_done,
    output reg         desc_req,
    output reg  [63:0] desc_addr,
    input  wire        desc_vld,
    input  wire [31:0] desc_base,
    input  wire [31:0] desc_limit,
    input  wire [15:0] desc_attr,
    input  wire        aux_wr,
    input  wire        aux_wr_two,
    input  wire [63:0] aux_wr_base,
    input  wire        tbl_ld,
    input  wire [1:0]  tbl_idx,
    input  wire [15:0] tbl_sel,
    input  wire [63:0] tbl_base,
    input  wire [31:0] tbl_limit,
    input  wire        int_req,
    input  wire [7:0]  int_vec,
    output reg         int_vld,
    output reg  [63:0] int_entry_addr,
    output reg         int_fault,
    input  wire        ag_req,
    input  wire [2:0]  ag_seg,
    input  wire [63:0] ag_ea,
    output reg         ag_vld,
    output reg  [63:0] ag_lin,
    output reg         ag_fault,
    output wire [1:0]  cs_descriptor_privilege,
    output wire        cs_default_size,
    output wire        cs_long,
    output wire [63:0] global_table_base_reg,
    output wire [63:0] local_table_base_reg,
    output wire [63:0] interrupt_table_base_reg,
    output wire [63:0] task_seg_pointer,
    output wire [31:0] task_seg_limit
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_FETCH = 1'b1;

    reg [2:0]  cur_mode_q;
    reg        st_q;
    reg [2:0]  pend_idx_q;
    reg [15:0] pend_sel_q;

    // visible and hidden parts of the six user segment registers
    reg [15:0] sel_q   [0:5];
    reg [63:0] base_q  [0:5];
    reg [31:0] limit_q [0:5];
    reg [15:0] attr_q  [0:5];

    // system-segment registers: base, limit, selector per table
    reg [63:0] tbase_q  [0:3];
    reg [31:0] tlimit_q [0:3];
    reg [15:0] tsel_q   [0:3];

    integer i;
    integer j;

    function is_shift_mode;
        input [2:0] m;
        begin
            is_shift_mode = (m == `SAG_MODE_REAL) || (m == `SAG_MODE_V86);
        end
    endfunction

    function is_aux;
        input [2:0] s;
        begin
            is_aux = (s == `SAG_SEG_AUX1) || (s == `SAG_SEG_AUX2);
        end
    endfunction

    function [63:0] shifted_base;
        input [15:0] s;
        begin
            shifted_base = {44'h0, s, 4'h0};
        end
    endfunction

    wire       any_ld   = seg_ld || far_ld;
    wire [2:0] ld_idx   = far_ld ? `SAG_SEG_CODE : seg_idx;
    wire       idx_ok   = (ld_idx <= `SAG_SEG_AUX2);
    wire       shift_md = is_shift_mode(cur_mode_q);
    wire       null_sel = (seg_sel[15:3] == 13'h0) &&
                          !seg_sel[`SAG_SEL_TI];
    wire       take_ld  = any_ld && idx_ok && (st_q == ST_IDLE);

    assign mode_cur = cur_mode_q;
    assign ld_busy  = (st_q == ST_FETCH);

    assign cs_descriptor_privilege =
        attr_q[`SAG_SEG_CODE][`SAG_ATTR_DPL_HI:`SAG_ATTR_DPL_LO];
    assign cs_default_size = attr_q[`SAG_SEG_CODE][`SAG_ATTR_DSIZE];
    assign cs_long         = attr_q[`SAG_SEG_CODE][`SAG_ATTR_LONG];

    assign global_table_base_reg    = tbase_q[`SAG_TBL_GLOBAL];
    assign local_table_base_reg     = tbase_q[`SAG_TBL_LOCAL];
    assign interrupt_table_base_reg = tbase_q[`SAG_TBL_INTR];
    assign task_seg_pointer         = tbase_q[`SAG_TBL_TASK];
    assign task_seg_limit           = tlimit_q[`SAG_TBL_TASK];

    // mode tracking; v86 interrupt forces legacy protected
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_mode_q <= `SAG_MODE_REAL;
        end else begin
            if (int_req && cur_mode_q == `SAG_MODE_V86) begin
                cur_mode_q <= `SAG_MODE_PROT;
            end else if (mode_wr && mode_val <= `SAG_MODE_LONG64) begin
                cur_mode_q <= mode_val;
            end
        end
    end

    // descriptor fetch sequencing
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q       <= ST_IDLE;
            pend_idx_q <= 3'h0;
            pend_sel_q <= 16'h0000;
            desc_req   <= 1'b0;
            desc_addr  <= 64'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    desc_req <= 1'b0;
                    // real and v86 loads never touch the tables
                    if (take_ld && !shift_md && !null_sel) begin
                        st_q       <= ST_FETCH;
                        pend_idx_q <= ld_idx;
                        pend_sel_q <= seg_sel;
                        desc_req   <= 1'b1;
                        desc_addr  <= (seg_sel[`SAG_SEL_TI] ?
                            tbase_q[`SAG_TBL_LOCAL] :
                            tbase_q[`SAG_TBL_GLOBAL]) +
                            {48'h0, seg_sel[15:3], 3'h0};
                    end
                end
                ST_FETCH: begin
                    if (desc_vld) begin
                        st_q     <= ST_IDLE;
                        desc_req <= 1'b0;
                    end
                end
                default: begin
                    st_q     <= ST_IDLE;
                    desc_req <= 1'b0;
                end
            endcase
        end
    end

    // segment register file
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ld_done <= 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                sel_q[i]   <= `SAG_RST_SEL;
                base_q[i]  <= `SAG_RST_BASE;
                limit_q[i] <= `SAG_RST_LIMIT;
                attr_q[i]  <= `SAG_RST_ATTR;
            end
        end else begin
            ld_done <= 1'b0;
            if (take_ld && shift_md) begin
                // limit and attributes left as they were
                sel_q[ld_idx]  <= seg_sel;
                base_q[ld_idx] <= shifted_base(seg_sel);
                ld_done        <= 1'b1;
            end else if (take_ld && null_sel) begin
                sel_q[ld_idx] <= seg_sel;
                ld_done       <= 1'b1;
            end else if (st_q == ST_FETCH && desc_vld) begin
                sel_q[pend_idx_q]   <= pend_sel_q;
                base_q[pend_idx_q]  <= {32'h0, desc_base};
                limit_q[pend_idx_q] <= desc_limit;
                attr_q[pend_idx_q]  <= desc_attr;
                ld_done             <= 1'b1;
            end else if (aux_wr) begin
                // direct full-width write of an auxiliary base
                if (aux_wr_two) begin
                    base_q[`SAG_SEG_AUX2] <= aux_wr_base;
                end else begin
                    base_q[`SAG_SEG_AUX1] <= aux_wr_base;
                end
            end
        end
    end

    // system-segment registers, kept in every mode
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < 4; j = j + 1) begin
                tbase_q[j]  <= `SAG_RST_BASE;
                tlimit_q[j] <= `SAG_RST_LIMIT;
                tsel_q[j]   <= `SAG_RST_SEL;
            end
        end else if (tbl_ld) begin
            tbase_q[tbl_idx]  <= tbl_base;
            tlimit_q[tbl_idx] <= tbl_limit;
            tsel_q[tbl_idx]   <= tbl_sel;
        end
    end

    // interrupt table entry address from the vector
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            int_vld        <= 1'b0;
            int_entry_addr <= 64'h0;
            int_fault      <= 1'b0;
        end else begin
            int_vld <= int_req;
            if (int_req) begin
                case (cur_mode_q)
                    `SAG_MODE_REAL: begin
                        int_entry_addr <= tbase_q[`SAG_TBL_INTR] +
                            {54'h0, int_vec, 2'h0};
                        int_fault <= ({22'h0, int_vec, 2'h3} >
                            tlimit_q[`SAG_TBL_INTR]);
                    end
                    `SAG_MODE_COMPAT, `SAG_MODE_LONG64: begin
                        int_entry_addr <= tbase_q[`SAG_TBL_INTR] +
                            {52'h0, int_vec, 4'h0};
                        int_fault <= ({20'h0, int_vec, 4'hf} >
                            tlimit_q[`SAG_TBL_INTR]);
                    end
                    default: begin
                        int_entry_addr <= tbase_q[`SAG_TBL_INTR] +
                            {53'h0, int_vec, 3'h0};
                        int_fault <= ({21'h0, int_vec, 3'h7} >
                            tlimit_q[`SAG_TBL_INTR]);
                    end
                endcase
            end
        end
    end

    // linear address generation
    reg [63:0] lin_d;
    reg        flt_d;
    reg [63:0] sum_d;

    always @* begin
        lin_d = 64'h0;
        flt_d = 1'b0;
        sum_d = base_q[ag_seg] + {32'h0, ag_ea[31:0]};
        case (cur_mode_q)
            `SAG_MODE_REAL, `SAG_MODE_V86: begin
                lin_d = (shifted_base(sel_q[ag_seg]) +
                    {48'h0, ag_ea[15:0]}) &
                    `SAG_REAL_MASK;
            end
            `SAG_MODE_PROT: begin
                lin_d = sum_d & `SAG_LOW4G_MASK;
                flt_d = (ag_ea[31:0] > limit_q[ag_seg]);
            end
            `SAG_MODE_COMPAT: begin
                lin_d = sum_d & `SAG_LOW4G_MASK;
                flt_d = (ag_ea[31:0] > limit_q[ag_seg]);
            end
            `SAG_MODE_LONG64: begin
                if (is_aux(ag_seg)) begin
                    lin_d = base_q[ag_seg] + ag_ea;
                end else begin
                    lin_d = ag_ea;
                end
            end
            default: begin
                lin_d = 64'h0;
                flt_d = 1'b1;
            end
        endcase
        // no such register: keep the unknown array read off the output
        if (ag_seg > `SAG_SEG_AUX2) begin
            lin_d = 64'h0;
            flt_d = 1'b1;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ag_vld   <= 1'b0;
            ag_lin   <= 64'h0;
            ag_fault <= 1'b0;
        end else begin
            ag_vld <= ag_req;
            if (ag_req) begin
                ag_lin   <= lin_d;
                ag_fault <= flt_d;
            end
        end
    end

endmodule

// ===== testbench/sag_chk_assertions.sv
module sag_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        mode_wr,
    input wire logic [2:0]  mode_val,
    input wire logic [2:0]  mode_cur,
    input wire logic        seg_ld,
    input wire logic        far_ld,
    input wire logic [2:0]  seg_idx,
    input wire logic [15:0] seg_sel,
    input wire logic        ld_busy,
    input wire logic        ld_done,
    input wire logic        desc_req,
    input wire logic [63:0] desc_addr,
    input wire logic        desc_vld,
    input wire logic        int_req,
    input wire logic        int_vld,
    input wire logic        ag_req,
    input wire logic [2:0]  ag_seg,
    input wire logic [63:0] ag_ea,
    input wire logic        ag_vld,
    input wire logic [63:0] ag_lin,
    input wire logic        ag_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire ld_go = (seg_ld || far_ld) && !ld_busy && (far_ld || seg_idx <= 3'h5);
    AST_RESET_REAL: assert property (
        $fell(rst) |-> mode_cur == 3'h0)
        else $error("mode not real after reset");
    AST_MODE_WR: assert property (
        mode_wr && mode_val <= 3'h4 && !int_req
        |=> mode_cur == $past(mode_val))
        else $error("mode write lost");
    AST_REAL_LIN: assert property (
        ag_req && mode_cur <= 3'h1 && ag_seg <= 3'h5
        |=> ag_vld && ag_lin[63:20] == 44'h0)
        else $error("real address beyond 1MB");
    AST_LD_REAL: assert property (
        ld_go && mode_cur <= 3'h1 |=> ld_done && !desc_req)
        else $error("real load fetched");
    AST_LD_PROT: assert property (
        ld_go && mode_cur >= 3'h2 && seg_sel[15:2] != 14'h0
        |=> desc_req && ld_busy && !ld_done)
        else $error("protected load did not fetch");
    AST_DESC_HOLD: assert property (
        desc_req && !desc_vld |=> desc_req && $stable(desc_addr))
        else $error("fetch dropped");
    AST_DESC_DONE: assert property (
        desc_req && desc_vld |=> !desc_req && ld_done)
        else $error("fetch not committed");
    AST_V86_INT: assert property (
        int_req && mode_cur == 3'h1 |=> mode_cur == 3'h2 && int_vld)
        else $error("v86 interrupt mode");
    AST_LONG_FLAT: assert property (
        ag_req && mode_cur == 3'h4 && ag_seg <= 3'h3
        |=> ag_lin == $past(ag_ea) && !ag_fault)
        else $error("64-bit base not zero");
    AST_COMPAT_4G: assert property (
        ag_req && mode_cur == 3'h3 && ag_seg <= 3'h5
        |=> ag_vld && ag_lin[63:32] == 32'h0)
        else $error("compat address above 4G");
    AST_SEG_RANGE: assert property (
        ag_req && ag_seg > 3'h5
        |=> ag_vld && ag_fault && ag_lin == 64'h0)
        else $error("unknown segment not faulted");
endmodule

bind sag_seg_addr_gen sag_chk i_chk (.sys_clk, .rst, .mode_wr, .mode_val,
    .mode_cur, .seg_ld, .far_ld, .seg_idx, .seg_sel, .ld_busy, .ld_done,
    .desc_req, .desc_addr, .desc_vld, .int_req, .int_vld, .ag_req, .ag_seg,
    .ag_ea, .ag_vld, .ag_lin, .ag_fault);

// ===== testbench/sag_desc_mem.sv
module sag_desc_mem (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        desc_req,
    input  wire logic [63:0] desc_addr,
    input  wire logic [3:0]  lat,
    output logic             desc_vld,
    output logic      [31:0] desc_base,
    output logic      [31:0] desc_limit,
    output logic      [15:0] desc_attr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // fields toggle between answers so stale data never matches
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {desc_vld, cnt, desc_base, desc_limit, desc_attr} <= '0;
        end else if (desc_req && !desc_vld && cnt == lat) begin
            desc_vld <= 1'b1;
            desc_base <= {desc_addr[27:0], 4'h0};
            desc_limit <= (desc_addr == 64'h0) ? 32'hffffffff :
                32'h000fffff;
            desc_attr <= desc_addr[3] ? 16'h2020 : 16'h4060;
        end else begin
            desc_vld <= 1'b0;
            cnt <= (desc_req && !desc_vld) ? cnt + 4'h1 : 4'h0;
            desc_base <= ~desc_base;
            desc_limit <= ~desc_limit;
            desc_attr <= ~desc_attr;
        end
    end
endmodule

// ===== testbench/tb_segment_address_generation.sv
module tb_segment_address_generation;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, mode_wr, seg_ld, far_ld, aux_wr, aux_wr_two, tbl_ld;
    logic int_req, ag_req;
    logic [2:0] mode_val, seg_idx, ag_seg;
    logic [1:0] tbl_idx;
    logic [3:0] lat;
    logic [7:0] int_vec;
    logic [15:0] seg_sel, tbl_sel;
    logic [31:0] tbl_limit;
    logic [63:0] aux_wr_base, tbl_base, ag_ea, daddr;
    wire [2:0] mode_cur;
    wire ld_busy, ld_done, desc_req, desc_vld, int_vld, int_fault;
    wire ag_vld, ag_fault, cs_default_size, cs_long;
    wire [1:0] cs_descriptor_privilege;
    wire [15:0] desc_attr;
    wire [31:0] desc_base, desc_limit, task_seg_limit;
    wire [63:0] desc_addr, int_entry_addr, ag_lin, global_table_base_reg;
    wire [63:0] local_table_base_reg, interrupt_table_base_reg;
    wire [63:0] task_seg_pointer;
    int fail_count = 0;
    int n_tests = 0;

    sag_seg_addr_gen i_dut (.sys_clk, .rst, .mode_wr, .mode_val, .mode_cur,
        .seg_ld, .far_ld, .seg_idx, .seg_sel, .ld_busy, .ld_done, .desc_req,
        .desc_addr, .desc_vld, .desc_base, .desc_limit, .desc_attr, .aux_wr,
        .aux_wr_two, .aux_wr_base, .tbl_ld, .tbl_idx, .tbl_sel, .tbl_base,
        .tbl_limit, .int_req, .int_vec, .int_vld, .int_entry_addr,
        .int_fault, .ag_req, .ag_seg, .ag_ea, .ag_vld, .ag_lin, .ag_fault,
        .cs_descriptor_privilege, .cs_default_size, .cs_long,
        .global_table_base_reg, .local_table_base_reg,
        .interrupt_table_base_reg, .task_seg_pointer, .task_seg_limit);
    sag_desc_mem i_mem (.sys_clk, .rst, .desc_req, .desc_addr, .lat,
        .desc_vld, .desc_base, .desc_limit, .desc_attr);

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(negedge sys_clk);
    endtask
    task automatic mode(input logic [2:0] m);
        mode_wr = 1;
        mode_val = m;
        tick;
        mode_wr = 0;
    endtask
    task automatic tbl(input logic [1:0] i, input logic [63:0] b,
                       input logic [31:0] l);
        tbl_ld = 1;
        tbl_idx = i;
        tbl_base = b;
        tbl_limit = l;
        tick;
        tbl_ld = 0;
    endtask
    task automatic aux(input logic two, input logic [63:0] b);
        aux_wr = 1;
        aux_wr_two = two;
        aux_wr_base = b;
        tick;
        aux_wr = 0;
    endtask
    // waits for the commit, catching the fetch address on the way
    task automatic seg(input logic f, input logic [2:0] i,
                       input logic [15:0] s);
        far_ld = f;
        seg_ld = !f;
        seg_idx = i;
        seg_sel = s;
        tick;
        {seg_ld, far_ld} = 2'b00;
        for (int k = 0; k < 40 && ld_done !== 1'b1; k++) begin
            if (desc_req === 1'b1)
                daddr = desc_addr;
            tick;
        end
        if (ld_done !== 1'b1) begin
            fail_count++;
            $display("BAD %0t load never committed", $time);
            give_verdict;
        end
    endtask
    task automatic ag(input logic [2:0] s, input logic [63:0] ea, e,
                      input logic f);
        ag_req = 1;
        ag_seg = s;
        ag_ea = ea;
        tick;
        ag_req = 0;
        chk(ag_vld, 1);
        chk(ag_lin, e);
        chk(ag_fault, f);
    endtask
    task automatic intr(input logic [7:0] v, input logic [63:0] e,
                        input logic f);
        int_req = 1;
        int_vec = v;
        tick;
        int_req = 0;
        chk(int_vld, 1);
        chk(int_entry_addr, e);
        chk(int_fault, f);
    endtask

    task t_real;
        for (int m = 0; m < 2; m++) begin
            mode(m[2:0]);
            seg(0, 3'h3, 16'h1234);
            ag(3'h3, 64'hfff0, 64'h22330, 0);
            seg(0, 3'h3, 16'hffff);
            ag(3'h3, 64'hffff, 64'hffef, 0);
            seg(1, 3'h3, 16'h2000);
            ag(3'h1, 64'h10, 64'h20010, 0);
            ag(3'h3, 64'h0, 64'hffff0, 0);
        end
        $display("done real and v86");
    endtask
    task t_prot;
        mode(3'h2);
        tbl(2'h0, 64'h1000, 32'hffff);
        tbl(2'h1, 64'h8000, 32'hffff);
        chk(local_table_base_reg, 64'h8000);
        chk(global_table_base_reg, 64'h1000);
        seg(0, 3'h3, 16'h0018);
        chk(daddr, 64'h1018);
        ag(3'h3, 64'h100, 64'h10280, 0);
        ag(3'h3, 64'h100000, 64'h110180, 1);
        lat = 4'h5;
        seg(1, 3'h0, 16'h000c);
        chk(daddr, 64'h8008);
        chk(cs_long, 1);
        chk(cs_descriptor_privilege, 1);
        chk(cs_default_size, 0);
        tbl(2'h1, 64'h0, 32'hffff);
        seg(0, 3'h2, 16'h0004);
        chk(daddr, 64'h0);
        ag(3'h2, 64'hffff_fff0, 64'hffff_fff0, 0);
        seg(0, 3'h0, 16'h0000);
        ag(3'h0, 64'h10, 64'h10, 0);
        mode(3'h3);
        ag(3'h3, 64'h7_0000_0100, 64'h10280, 0);
        ag(3'h6, 64'h10, 64'h0, 1);
        $display("done protected");
    endtask
    task t_long;
        mode(3'h4);
        aux(0, 64'h1234_5678_0000_0000);
        ag(3'h4, 64'h10, 64'h1234_5678_0000_0010, 0);
        ag(3'h3, 64'hffff_0000_0000_0010,
           64'hffff_0000_0000_0010, 0);
        aux(1, 64'hffff_0000_0000_0000);
        seg(0, 3'h5, 16'h0020);
        ag(3'h5, 64'h0, 64'h10200, 0);
        tbl(2'h3, 64'h9000, 32'h67);
        chk(task_seg_pointer, 64'h9000);
        chk(task_seg_limit, 64'h67);
        tbl(2'h2, 64'h4000, 32'hffff);
        chk(interrupt_table_base_reg, 64'h4000);
        intr(8'h03, 64'h4030, 0);
        tbl(2'h2, 64'h4000, 32'h2f);
        intr(8'h03, 64'h4030, 1);
        mode(3'h1);
        intr(8'h03, 64'h4018, 0);
        chk(mode_cur, 2);
        mode(3'h0);
        intr(8'h03, 64'h400c, 0);
        $display("done 64-bit and interrupts");
    endtask

    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1;
        lat = 4'h0;
        daddr = '0;
        {mode_wr, mode_val, seg_ld, far_ld, seg_idx, seg_sel, aux_wr,
         aux_wr_two, aux_wr_base, tbl_ld, tbl_idx, tbl_base, tbl_limit,
         int_req, int_vec, ag_req, ag_seg, ag_ea} = '0;
        tbl_sel = 16'h0008;
        repeat (20) tick;
        rst = 0;
        chk(mode_cur, 0);
        t_real;
        t_prot;
        t_long;
        give_verdict;
    end
endmodule
